// >>> design/iexp_top.sv
// Serial slave front end of an eight-input expander with change flags,
// an interrupt-enable mask and an active-low alert output.
// Assumes an external bus master drives scl slowly (several clk_sys per
// phase) and that the board resolves sda from sda_oe with a pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "iexp_defines.svh"

module iexp_top
  import iexp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire iexp_pkg::iexp_port_t port_in,
  input wire logic [1:0] addr_select_high,
  input wire logic [1:0] addr_select_low,
  output logic alert_n
);

  import iexp_pkg::*;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Synchronised pins
  logic [1:0] bus_s;
  logic [11:0] pin_s;
  logic scl_s;
  logic sda_s;
  iexp_port_t port_s;
  logic [3:0] sel_s;

  // Edge history and bus events
  logic scl_p_q;
  logic sda_p_q;
  logic scl_rise;
  logic scl_fall;
  logic start_p;
  logic stop_p;

  // Protocol state
  iexp_state_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic dir_q;
  logic nxt_lvl_q;
  logic oe_q;
  logic out_q;
  logic addr_hit;

  // Change detection and alert state
  iexp_port_t snap_q;
  iexp_port_t flag_q;
  iexp_port_t flag_sv_q;
  iexp_port_t mask_q;
  logic rd_act_q;
  logic alert_n_q;
  logic clr_p;
  logic ld_mask;
  logic lvl_load;

  // Bus lines idle high so reset cannot fake a START
  iexp_sync #(.W(2), .RST_VAL(`IEXP_BUS_IDLE)) u_bus_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({scl_in, sda_in}),
    .q(bus_s)
  );

  // Ports and select straps share one synchroniser
  iexp_sync #(.W(12), .RST_VAL(`IEXP_PIN_RST)) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({port_in, addr_select_high, addr_select_low}),
    .q(pin_s)
  );

  assign scl_s = bus_s[1];
  assign sda_s = bus_s[0];
  assign port_s = pin_s[11:4];
  assign sel_s = pin_s[3:0];

  // Previous samples for edge finding
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // Bus events; data moves only on scl edges
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_p = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_p = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Fixed upper bits then select pins; low bit of sh_q is direction
  assign addr_hit = (sh_q[7:1] == {`IEXP_ADDR_FIXED, sel_s});

  // Access acknowledge: address ack, or master ack before a level byte
  assign lvl_load = scl_rise & (st_q == IEXP_ST_RD_ACK) & ~sda_s & nxt_lvl_q;
  assign clr_p = (scl_rise & (st_q == IEXP_ST_ADDR_ACK)) | lvl_load;
  assign ld_mask = scl_rise & (st_q == IEXP_ST_WR_ACK);

  // Protocol sequencer; START or STOP override any bit in flight
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= IEXP_ST_IDLE;
      cnt_q <= `IEXP_CNT_ZERO;
      sh_q <= `IEXP_BYTE_ZERO;
      dir_q <= 1'b0;
      nxt_lvl_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start_p) begin
      st_q <= IEXP_ST_ADDR;
      cnt_q <= `IEXP_CNT_ZERO;
      oe_q <= 1'b0;
    end else if (stop_p) begin
      st_q <= IEXP_ST_IDLE;
      oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        IEXP_ST_IDLE: begin
          oe_q <= 1'b0;
        end
        IEXP_ST_ADDR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + `IEXP_CNT_ONE;
          end else if (scl_fall && cnt_q == `IEXP_BYTE_BITS) begin
            if (addr_hit) begin
              dir_q <= sh_q[0];
              oe_q <= 1'b1;
              st_q <= IEXP_ST_ADDR_ACK;
            end else begin
              st_q <= IEXP_ST_IDLE; // Not ours: sit out until START
            end
          end
        end
        IEXP_ST_ADDR_ACK: begin
          if (scl_rise && dir_q) begin
            sh_q <= port_s;
            nxt_lvl_q <= 1'b0;
          end else if (scl_fall) begin
            cnt_q <= `IEXP_CNT_ZERO;
            oe_q <= dir_q & ~sh_q[7];
            st_q <= dir_q ? IEXP_ST_RD_DATA : IEXP_ST_WR_DATA;
          end
        end
        IEXP_ST_WR_DATA: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s};
            cnt_q <= cnt_q + `IEXP_CNT_ONE;
          end else if (scl_fall && cnt_q == `IEXP_BYTE_BITS) begin
            oe_q <= 1'b1;
            st_q <= IEXP_ST_WR_ACK;
          end
        end
        IEXP_ST_WR_ACK: begin
          if (scl_fall) begin
            oe_q <= 1'b0;
            cnt_q <= `IEXP_CNT_ZERO;
            st_q <= IEXP_ST_WR_DATA;
          end
        end
        IEXP_ST_RD_DATA: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + `IEXP_CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_q == `IEXP_BYTE_BITS) begin
              oe_q <= 1'b0; // Master owns the ack slot
              st_q <= IEXP_ST_RD_ACK;
            end else begin
              sh_q <= {sh_q[6:0], 1'b0};
              oe_q <= ~sh_q[6];
            end
          end
        end
        IEXP_ST_RD_ACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              st_q <= IEXP_ST_IDLE;
            end else begin
              sh_q <= nxt_lvl_q ? port_s : flag_sv_q;
              nxt_lvl_q <= ~nxt_lvl_q;
            end
          end else if (scl_fall) begin
            cnt_q <= `IEXP_CNT_ZERO;
            oe_q <= ~sh_q[7];
            st_q <= IEXP_ST_RD_DATA;
          end
        end
      endcase
    end
  end

  // Open drain: the data driven is always low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_q <= 1'b0;
    end else begin
      out_q <= 1'b0;
    end
  end

  // Reference copy reloads with exactly the levels being sent
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      snap_q <= `IEXP_BYTE_ZERO;
      flag_sv_q <= `IEXP_BYTE_ZERO;
    end else if (clr_p) begin
      snap_q <= port_s;
      flag_sv_q <= flag_q;
    end
  end

  // Per-port sticky flag; a change in the clear cycle lands in snap_q
  for (genvar i = 0; i < `IEXP_PORTS; i++) begin : g_flag
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        flag_q[i] <= 1'b0;
      end else if (clr_p) begin
        flag_q[i] <= 1'b0;
      end else if (port_s[i] != snap_q[i]) begin
        flag_q[i] <= 1'b1;
      end
    end
  end

  // Interrupt enable mask, reloaded by every written byte
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_q <= `IEXP_MASK_RST;
    end else if (ld_mask) begin
      mask_q <= sh_q;
    end
  end

  // Read in progress from address ack to STOP or a new START
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_act_q <= 1'b0;
    end else if (start_p || stop_p) begin
      rd_act_q <= 1'b0;
    end else if (scl_rise && st_q == IEXP_ST_ADDR_ACK && dir_q) begin
      rd_act_q <= 1'b1;
    end
  end

  // Alert held off during reads to avoid handler re-entry
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alert_n_q <= 1'b1;
    end else begin
      alert_n_q <= rd_act_q | ~(|(flag_q & mask_q));
    end
  end

  assign sda_out = out_q;
  assign sda_oe = oe_q;
  assign alert_n = alert_n_q;

  sda_low_only_a: assert property (!sda_out)
    else $error("sda driven high");

  flag_sticky_a: assert property (
    !clr_p |=> (flag_q & $past(flag_q)) == $past(flag_q))
    else $error("change flag dropped without access");

  flag_set_a: assert property (
    !clr_p |=> ($past(port_s ^ snap_q) & ~flag_q) == 8'h00)
    else $error("mismatch did not set flag");

  clear_ref_a: assert property (
    clr_p |=> snap_q == $past(port_s) && flag_q == 8'h00
      && flag_sv_q == $past(flag_q))
    else $error("access ack did not reload reference");

  read_quiet_a: assert property (rd_act_q |=> alert_n)
    else $error("alert asserted during read");

  alert_mask_a: assert property (
    !rd_act_q && (flag_q & mask_q) != 8'h00 |=> !alert_n)
    else $error("enabled flag did not raise alert");

  mask_load_a: assert property (ld_mask |=> mask_q == $past(sh_q))
    else $error("written byte not loaded into mask");

  addr_miss_a: assert property (
    st_q == IEXP_ST_ADDR && scl_fall && cnt_q == `IEXP_BYTE_BITS
      && !addr_hit |=> !sda_oe ##1 st_q == IEXP_ST_IDLE || start_p)
    else $error("foreign address acknowledged");

  start_seen_a: assert property (start_p |=> st_q == IEXP_ST_ADDR)
    else $error("START not taken");

  drive_window_a: assert property (
    sda_oe |-> st_q inside {IEXP_ST_ADDR_ACK, IEXP_ST_WR_ACK,
      IEXP_ST_RD_DATA})
    else $error("sda pulled outside ack or read data");

endmodule // iexp_top

`default_nettype wire

// >>> design/iexp_defines.svh
// Constants for the eight-input change-detect expander serial front end.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef IEXP_DEFINES_SVH
`define IEXP_DEFINES_SVH

`define IEXP_PORTS 8
`define IEXP_ADDR_FIXED 3'h6
`define IEXP_BYTE_BITS 4'h8
`define IEXP_CNT_ZERO 4'h0
`define IEXP_CNT_ONE 4'h1
`define IEXP_MASK_RST 8'h00
`define IEXP_BYTE_ZERO 8'h00
`define IEXP_BUS_IDLE 2'h3
`define IEXP_PIN_RST 12'h000

`endif

// >>> design/iexp_pkg.sv
// Types shared by the expander serial front end.
// Assumes the defines header is on the include path.
`include "iexp_defines.svh"

package iexp_pkg;

  typedef logic [`IEXP_PORTS-1:0] iexp_port_t;

  // Serial protocol states
  typedef enum logic [2:0] {
    IEXP_ST_IDLE,
    IEXP_ST_ADDR,
    IEXP_ST_ADDR_ACK,
    IEXP_ST_WR_DATA,
    IEXP_ST_WR_ACK,
    IEXP_ST_RD_DATA,
    IEXP_ST_RD_ACK
  } iexp_state_e;

endpackage

// >>> design/iexp_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence implied.
`timescale 1ns/1ps
`default_nettype none

module iexp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // iexp_sync

`default_nettype wire

// >>> dv/iexp_master_model.sv
// Behavioural bus master that frames transfers to the expander.
// Assumes sda is resolved outside from both pull-downs and a pull-up.
`timescale 1ns/1ps
`default_nettype none

module iexp_master_model (
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Clock idles high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Data moves one clock after scl falls, never while it is high
  task automatic bit_out(input logic b);
    tick(1);
    sda_pull = ~b;
    tick(3);
    scl = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  // Released line, sampled mid high phase
  task automatic bit_in(output logic b);
    tick(1);
    sda_pull = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(2);
    b = sda;
    tick(2);
    scl = 1'b0;
  endtask

  task automatic start();
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(1);
    sda_pull = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(8);
  endtask

  // MSB first, then the receiver's acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(ack_n);
  endtask

  // Every byte but the last is acknowledged
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    bit_out(last);
  endtask
endmodule // iexp_master_model

`default_nettype wire

// >>> dv/i2c_input_expander_change_detect_tb.sv
// Self-checking bench for the expander front end.
// Assumes the master model drives the bus; sda has a pull-up here.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) begin comparisons++; \
  if ((got) !== (exp)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end

module i2c_input_expander_change_detect_tb;
  import iexp_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_pull, sda_out, sda_oe, alert_n, ack_n;
  wire logic sda;
  iexp_port_t port_in = '0;
  logic [1:0] sel_hi = 2'h2;
  logic [1:0] sel_lo = 2'h1;
  logic [7:0] rd_q [4];
  logic [7:0] bad [3] = '{8'h02, 8'h10, 8'h40};
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  // Open drain with pull-up: low if either side pulls
  assign sda = ~(sda_pull | sda_oe);

  always #50 clk_sys = ~clk_sys;

  iexp_master_model mst_u (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .sda_pull(sda_pull));

  iexp_top dut_u (.clk_sys(clk_sys), .rst(rst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .port_in(port_in),
    .addr_select_high(sel_hi), .addr_select_low(sel_lo),
    .alert_n(alert_n));

  // Device may only pull low, never drive high
  always @(negedge clk_sys) begin
    if (sda_oe) `CHECK("sda_out", 1'b0, sda_out)
  end

  // A hung bus must not stall the run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] adr(input logic rw);
    return {3'h6, sel_hi, sel_lo, rw};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] b, input int n);
    mst_u.start();
    mst_u.put_byte(adr(1'b0), ack_n);
    `CHECK("addr ack", 1'b0, ack_n)
    for (int i = 0; i < n; i++) begin
      mst_u.put_byte(i ? b : a, ack_n);
      `CHECK("data ack", 1'b0, ack_n)
    end
    mst_u.stop();
  endtask

  task automatic rd(input int n);
    mst_u.start();
    mst_u.put_byte(adr(1'b1), ack_n);
    `CHECK("addr ack", 1'b0, ack_n)
    for (int i = 0; i < n; i++) begin
      mst_u.get_byte(i == n - 1, rd_q[i]);
    end
    mst_u.stop();
  endtask

  task automatic wait_chk(input int n, input logic exp);
    repeat (n) @(negedge clk_sys);
    `CHECK("alert_n", exp, alert_n)
  endtask

  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    rd(1);
    `CHECK("levels", 8'h00, rd_q[0])
    // Short pulse returns to the old level but stays flagged
    port_in = 8'h5a;
    repeat (5) @(negedge clk_sys);
    port_in = 8'h00;
    repeat (5) @(negedge clk_sys);
    rd(2);
    `CHECK("levels", 8'h00, rd_q[0])
    `CHECK("flags", 8'h5a, rd_q[1])
    rd(2);
    `CHECK("flags", 8'h00, rd_q[1])
    wr(8'h0f, 8'h00, 1);
    port_in = 8'h30;
    wait_chk(8, 1'b1);
    port_in = 8'h31;
    wait_chk(8, 1'b0);
    wr(8'hf0, 8'h00, 1);
    wait_chk(1, 1'b1);
    port_in = 8'h21;
    wait_chk(8, 1'b0);
    // Only the last byte of a long write stays in the mask
    wr(8'hff, 8'h01, 2);
    port_in = 8'h23;
    wait_chk(8, 1'b1);
    port_in = 8'h22;
    wait_chk(8, 1'b0);
    // Change while the level byte shifts out
    fork
      rd(1);
      begin
        wait_chk(100, 1'b1);
        port_in = 8'h23;
        wait_chk(20, 1'b1);
      end
    join
    `CHECK("levels", 8'h22, rd_q[0])
    wait_chk(5, 1'b0);
    // Long read: change lands in the second pair
    fork
      rd(4);
      wait_chk(190, 1'b1);
    join_any
    port_in = 8'ha3;
    wait fork;
    `CHECK("pair1 levels", 8'h23, rd_q[0])
    `CHECK("pair1 flags", 8'h01, rd_q[1])
    `CHECK("pair2 levels", 8'ha3, rd_q[2])
    `CHECK("pair2 flags", 8'h80, rd_q[3])
    wait_chk(5, 1'b1);
    // Foreign addresses get no acknowledge
    for (int k = 0; k < 3; k++) begin
      mst_u.start();
      mst_u.put_byte(adr(1'b1) ^ bad[k], ack_n);
      `CHECK("foreign ack", 1'b1, ack_n)
      mst_u.stop();
    end
    sel_hi = 2'h1;
    sel_lo = 2'h2;
    repeat (4) @(negedge clk_sys);
    rd(1);
    `CHECK("levels", 8'ha3, rd_q[0])
    give_verdict();
  end
endmodule // i2c_input_expander_change_detect_tb

`default_nettype wire
